/* File: design/radio_coexistence_signals.sv */
// Purpose: Three-pin coexistence signalling toward a companion radio.
// Assumes: Cellular time-mark tick arrives from logic on clk.
// Notes: The one-second mark is counted locally from clk while positioning is in use.
//        The activity input comes from a pin and is synchronised before use.
//        Every output is registered, so each answer lags its cause by whole cycles.
// How it works
// - Three pins: one input, two outputs.
// - Activity pin may act as amplifier enable.
// - Time mark pulses on cellular time ticks.
// - Positioning mode gives one pulse per second.
// - Activity output follows modem transceiver on.
`timescale 1ns/1ns
`include "coex_cfg.svh"

module radio_coexistence_signals #(
    parameter int PPS_PERIOD_CYC = `COEX_PPS_PERIOD_CYC
) (
    input wire logic clk,
    input wire logic nrst,
    input wire logic ext_radio_active_in,
    input wire logic gnss_in_use,
    input wire logic cell_time_tick,
    input wire logic modem_trx_on,
    output logic time_mark_out,
    output logic modem_radio_active_out,
    output logic ext_radio_active,
    output logic gnss_lna_enable
);

    // ----------------------------------------------------------------
    // Input synchroniser
    // ----------------------------------------------------------------
    logic sync_a;
    logic sync_b;
    logic next_sync_a;
    logic next_sync_b;

    // The first stage is read only by the second stage.
    // The pin may change at any time, so the first stage can go metastable;
    // it is given a whole cycle to settle before anything else looks at it.
    always_comb
    begin
        next_sync_a = ext_radio_active_in;
        next_sync_b = sync_a;
    end

    // Registers the synchroniser stages.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            sync_a <= 1'b0;
            sync_b <= 1'b0;
        end
        else
        begin
            sync_a <= next_sync_a;
            sync_b <= next_sync_b;
        end
    end

    // ----------------------------------------------------------------
    // Activity and time mark outputs
    // ----------------------------------------------------------------
    logic [31:0] pps_cnt;
    logic [31:0] next_pps_cnt;
    logic next_time_mark;
    logic next_modem_active;
    logic next_ext_active;
    logic next_lna;
    coex_pkg::mark_src_t src;

    // Chooses the mark source and counts the one-second period.
    // The counter rests at zero outside positioning mode, so the first second
    // mark comes one full period after the mode is entered.
    // Cellular ticks are ignored while positioning owns the mark.
    always_comb
    begin
        src = gnss_in_use ? coex_pkg::MARK_PPS : coex_pkg::MARK_CELL;
        next_pps_cnt = 32'h0;
        next_time_mark = 1'b0;
        case (src)
            coex_pkg::MARK_CELL:
            begin
                next_time_mark = cell_time_tick;
            end
            coex_pkg::MARK_PPS:
            begin
                if (pps_cnt >= 32'(PPS_PERIOD_CYC - 1))
                begin
                    next_pps_cnt = 32'h0;
                    next_time_mark = 1'b1;
                end
                else
                begin
                    next_pps_cnt = pps_cnt + 32'h1;
                end
            end
            default:
            begin
                next_time_mark = 1'b0;
            end
        endcase
        next_modem_active = modem_trx_on;
        next_ext_active = gnss_in_use ? 1'b0 : sync_b;
        next_lna = gnss_in_use ? sync_b : 1'b0;
    end

    // Registers the outputs so the pins are glitch free.
    // Reset clears every pin, which the companion reads as a grant.
    always_ff @(posedge clk)
    begin
        if (!nrst)
        begin
            pps_cnt <= 32'h0;
            time_mark_out <= 1'b0;
            modem_radio_active_out <= 1'b0;
            ext_radio_active <= 1'b0;
            gnss_lna_enable <= 1'b0;
        end
        else
        begin
            pps_cnt <= next_pps_cnt;
            time_mark_out <= next_time_mark;
            modem_radio_active_out <= next_modem_active;
            ext_radio_active <= next_ext_active;
            gnss_lna_enable <= next_lna;
        end
    end

    // ----------------------------------------------------------------
    // Assertions
    // ----------------------------------------------------------------
    // Every check is switched off while reset is held; checks that look back
    // in time demand that reset was released on the cycles they see, except the reset check, which demands it held.

    // Checks that the activity input reaches its output three edges late.
    property p_sync_delay;
        @(posedge clk) disable iff (!nrst)
        !gnss_in_use[*3] ##0 ($past(nrst, 3) && $past(nrst, 2) && $past(nrst))
            |-> ext_radio_active == $past(ext_radio_active_in, 3);
    endproperty
    a_sync_delay: assert property (p_sync_delay) else $error("Activity input delay wrong.");

    // Checks that every output and the counter come out of reset clear.
    property p_reset_quiet;
        @(posedge clk) disable iff (!nrst)
        !$past(nrst) |-> !time_mark_out && !modem_radio_active_out && !ext_radio_active
            && !gnss_lna_enable && pps_cnt == 32'h0;
    endproperty
    a_reset_quiet: assert property (p_reset_quiet) else $error("Reset not clean.");

    // Checks that the second counter rests at zero outside positioning mode.
    property p_cnt_idle;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && !$past(gnss_in_use) |-> pps_cnt == 32'h0;
    endproperty
    a_cnt_idle: assert property (p_cnt_idle) else $error("Second count not idle.");

    // Checks that entering positioning mode starts the second count from zero.
    property p_pps_start;
        @(posedge clk) disable iff (!nrst)
        PPS_PERIOD_CYC > 1 && $past(nrst) && gnss_in_use && !$past(gnss_in_use)
            |=> pps_cnt == 32'h1;
    endproperty
    a_pps_start: assert property (p_pps_start) else $error("Second count start wrong.");

    // Checks that the synchronised level reaches its output outside positioning mode.
    property p_ext_path;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && !$past(gnss_in_use) |-> ext_radio_active == $past(sync_b);
    endproperty
    a_ext_path: assert property (p_ext_path) else $error("Activity output wrong.");

    // Checks that the modem activity output follows the transceiver.
    property p_active_follow;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) |-> modem_radio_active_out == $past(modem_trx_on);
    endproperty
    a_active_follow: assert property (p_active_follow) else $error("Modem activity wrong.");

    // Checks that a cellular tick gives a mark on the next edge.
    property p_cell_mark;
        @(posedge clk) disable iff (!nrst)
        (!gnss_in_use && cell_time_tick) |=> time_mark_out;
    endproperty
    a_cell_mark: assert property (p_cell_mark) else $error("Cell mark missing.");

    // Checks that no mark appears without a cellular tick.
    property p_no_cell_mark;
        @(posedge clk) disable iff (!nrst)
        (!gnss_in_use && !cell_time_tick) |=> !time_mark_out;
    endproperty
    a_no_cell_mark: assert property (p_no_cell_mark) else $error("Spurious mark.");

    // Checks that the end of the count gives a mark and restarts the count.
    property p_pps_mark;
        @(posedge clk) disable iff (!nrst)
        (gnss_in_use && pps_cnt == 32'(PPS_PERIOD_CYC - 1)) |=> time_mark_out && pps_cnt == 32'h0;
    endproperty
    a_pps_mark: assert property (p_pps_mark) else $error("Second mark missing.");

    // Checks that no mark appears before the count ends.
    property p_pps_quiet;
        @(posedge clk) disable iff (!nrst)
        (gnss_in_use && pps_cnt < 32'(PPS_PERIOD_CYC - 1)) |=> !time_mark_out;
    endproperty
    a_pps_quiet: assert property (p_pps_quiet) else $error("Early second mark.");

    // Checks that positioning mode routes the pin to the amplifier enable.
    property p_lna_mode;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && $past(gnss_in_use) |-> gnss_lna_enable == $past(sync_b) && !ext_radio_active;
    endproperty
    a_lna_mode: assert property (p_lna_mode) else $error("Amplifier enable wrong.");

    // Checks that the amplifier enable stays low outside positioning mode.
    property p_ext_mode;
        @(posedge clk) disable iff (!nrst)
        $past(nrst) && !$past(gnss_in_use) |-> !gnss_lna_enable;
    endproperty
    a_ext_mode: assert property (p_ext_mode) else $error("Enable in wrong mode.");

    // Main scenarios: both mark sources, a grant, the amplifier enable and a reset.
    c_cell: cover property (@(posedge clk) disable iff (!nrst) !gnss_in_use && time_mark_out);
    c_pps: cover property (@(posedge clk) disable iff (!nrst) gnss_in_use && time_mark_out);
    c_grant: cover property (@(posedge clk) disable iff (!nrst) $fell(modem_radio_active_out));
    c_lna: cover property (@(posedge clk) disable iff (!nrst) gnss_lna_enable);
    c_reset: cover property (@(posedge clk) disable iff (!nrst) $rose(nrst));

endmodule

/* File: design/coex_cfg.svh */
// Purpose: Constants for the radio coexistence signalling block.
// Assumes: A 10 MHz system clock.
// Notes: Times are given in their own unit and converted to cycles here.
`ifndef COEX_CFG_SVH
`define COEX_CFG_SVH

// ----------------------------------------------------------------
// Timing
// ----------------------------------------------------------------
`define COEX_CLK_PERIOD_NS 100
`define COEX_PPS_PERIOD_NS 1000000000
`define COEX_PPS_PERIOD_CYC (`COEX_PPS_PERIOD_NS / `COEX_CLK_PERIOD_NS)
`define COEX_PULSE_WIDTH_CYC 1
`define COEX_SYNC_STAGES 2

`endif

/* File: design/coex_pkg.sv */
// Purpose: Types for the radio coexistence signalling block.
// Assumes: Nothing beyond the constants header.
// Notes: Only types live here.
package coex_pkg;

    // Source selected for the time-mark output.
    typedef enum logic {MARK_CELL, MARK_PPS} mark_src_t;

endpackage

/* File: sim/coex_companion.sv */
// Purpose: Companion radio model that drives the activity pin.
// Assumes: The bench says when the companion transceiver wants to run.
// Notes: The companion runs only while the modem grant (active low) is given.
`timescale 1ns/1ns
module coex_companion (
    input wire logic want_on,
    input wire logic grant_n,
    output logic active_pin
);
    // The pin is high only while the transceiver runs under a grant.
    assign active_pin = want_on & ~grant_n;
endmodule

/* File: sim/radio_coexistence_signals_bench.sv */
// Purpose: Self-checking bench for the coexistence signalling block.
// Assumes: The one-second count is shortened to 10 cycles.
// Notes: Inputs change on the falling edge and are checked there too.
`timescale 1ns/1ns
module radio_coexistence_signals_bench;
    logic clk = 0, nrst = 0, tick = 0, trx = 0, gnss = 0, want = 0;
    logic pin, mark, act, ext, lna;
    int bad_count = 0, comparisons = 0, cyc = 0, k;
    // --------------------------------
    // Clock, parts and timeout
    // --------------------------------
    initial forever #50 clk = ~clk;
    coex_companion u_peer (.want_on(want), .grant_n(act), .active_pin(pin));
    radio_coexistence_signals #(.PPS_PERIOD_CYC(10)) u_dut (.clk(clk), .nrst(nrst),
        .ext_radio_active_in(pin), .gnss_in_use(gnss), .cell_time_tick(tick),
        .modem_trx_on(trx), .time_mark_out(mark), .modem_radio_active_out(act),
        .ext_radio_active(ext), .gnss_lna_enable(lna));
    // Cuts a hang short.
    always @(posedge clk)
    begin
        cyc++;
        if (cyc == 400)
        begin
            bad_count++;
            give_verdict();
        end
    end
    // Compares one bit and counts the result.
    task automatic chk(input string n, input logic e, input logic g);
        comparisons++;
        if (g !== e)
        begin
            bad_count++;
            $display("[FAIL] %s expected %b seen %b", n, e, g);
        end
    endtask
    task automatic step(input int n);
        repeat (n) @(negedge clk);
    endtask
    // Prints the counts and the verdict, then stops.
    task automatic give_verdict();
        $display("comparisons %0d mismatches %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0)
            $display("NO MISMATCHES");
        else
            $display("MISMATCHES SEEN");
        $finish;
    endtask
    // Counts falling edges until the next mark, giving up after 20.
    task automatic wait_mark(output int n);
        n = 0;
        do
        begin
            step(1);
            n++;
        end while (mark !== 1'b1 && n < 20);
    endtask
    // Back-to-back cellular ticks give a mark one cycle later each.
    task automatic t_tick();
        tick = 1;
        step(1);
        chk("mark first", 1'b1, mark);
        step(1);
        tick = 0;
        chk("mark second", 1'b1, mark);
        step(1);
        chk("mark end", 1'b0, mark);
        $display("test tick done");
    endtask
    // The activity output follows the transceiver; the companion waits for the grant.
    task automatic t_trx();
        trx = 1;
        step(1);
        chk("active on", 1'b1, act);
        want = 1;
        step(4);
        chk("grant withheld", 1'b0, ext);
        trx = 0;
        step(1);
        chk("active off", 1'b0, act);
        step(3);
        chk("grant given", 1'b1, ext);
        want = 0;
        step(3);
        $display("test trx done");
    endtask
    // The companion pin shows only after the two-stage synchroniser.
    task automatic t_ext();
        want = 1;
        step(2);
        chk("ext early", 1'b0, ext);
        step(1);
        chk("ext seen", 1'b1, ext);
        chk("lna idle", 1'b0, lna);
        want = 0;
        step(3);
        chk("ext gone", 1'b0, ext);
        $display("test ext done");
    endtask
    // Positioning mode: one mark per period, cellular ticks ignored.
    task automatic t_pps();
        gnss = 1;
        tick = 1;
        want = 1;
        repeat (2)
        begin
            wait_mark(k);
            chk("pps period", 1'b1, k == 10);
        end
        chk("lna on", 1'b1, lna);
        chk("ext masked", 1'b0, ext);
        gnss = 0;
        tick = 0;
        want = 0;
        step(3);
        $display("test pps done");
    endtask
    // A reset in positioning mode clears the amplifier enable and restarts the second count.
    task automatic t_reset();
        gnss = 1;
        want = 1;
        step(4);
        chk("lna before reset", 1'b1, lna);
        nrst = 0;
        step(1);
        chk("reset mid lna", 1'b0, lna);
        nrst = 1;
        wait_mark(k);
        chk("pps after reset", 1'b1, k == 10);
        chk("lna after reset", 1'b1, lna);
        gnss = 0;
        want = 0;
        step(3);
        $display("test reset done");
    endtask
    initial
    begin
        step(2);
        chk("reset mark", 1'b0, mark);
        chk("reset active", 1'b0, act);
        chk("reset ext", 1'b0, ext);
        chk("reset lna", 1'b0, lna);
        nrst = 1;
        t_tick();
        t_trx();
        t_ext();
        t_pps();
        t_reset();
        give_verdict();
    end
endmodule
